/* rtl/lcg_input_select.sv */
// gate input select section of one configurable logic cell, with its register port
//
// Behaviour
// - six-bit field, bits 5..0 of data four select, picks the fourth channel source
// - bits 7 and 6 of data four select read zero and hold nothing
// - select field and gate enables are read/write; only power-on reset touches them
// - gate zero enable bits 7/6..1/0 pass channels four..one true and inverted
// - gate one enable bit pairs pass channels four..one true and inverted
// - gate two enable bit pairs pass channels four..one true and inverted
// - a cleared enable bit drops that signal, a set bit adds it
// - channels one to four are cell input lines zero to three
// - each gate output has its own polarity bit that inverts it
`timescale 1ns/10ps
`default_nettype none
`include "lcg_cfg.svh"

module lcg_input_select (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire lcg_pkg::lcg_bus_req_t busReq,
    output logic [7:0]                rdData,
    input  wire logic [2:0]           cellLinesLow,
    input  wire logic [63:0]          sourceBus,
    output logic [2:0]                gateOut
);

    // stored configuration
    logic [5:0]             dFourSel_r;
    logic [5:0]             dFourSel_nxt;
    lcg_pkg::lcg_gate_sel_t gateSel_r   [3];
    lcg_pkg::lcg_gate_sel_t gateSel_nxt [3];
    logic [2:0]             gateInv_r;
    logic [2:0]             gateInv_nxt;

    // read port and gate outputs
    logic [7:0]             rdData_r;
    logic [7:0]             rdData_nxt;
    logic [2:0]             gateOut_r;
    logic [2:0]             gateOut_nxt;

    // datapath
    logic                   lineThree;
    logic [3:0]             cellLines;
    logic [2:0]             gateValue;

    // register writes; unmapped offsets are ignored
    always_comb begin
        dFourSel_nxt = dFourSel_r;
        gateSel_nxt  = gateSel_r;
        gateInv_nxt  = gateInv_r;
        if (busReq.wr) begin
            unique case (busReq.addr)
                `LCG_OFS_DFOUR: begin
                    dFourSel_nxt = busReq.wdata[`LCG_DFOUR_MSB:`LCG_DFOUR_LSB];
                end
                `LCG_OFS_GATE0: begin
                    gateSel_nxt[0] = busReq.wdata;
                end
                `LCG_OFS_GATE1: begin
                    gateSel_nxt[1] = busReq.wdata;
                end
                `LCG_OFS_GATE2: begin
                    gateSel_nxt[2] = busReq.wdata;
                end
                `LCG_OFS_POL: begin
                    gateInv_nxt = busReq.wdata[`LCG_POL_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // resetn stands for power-on and brown-out: the contents are undefined there,
    // so zero is a legal pick; no other reset reaches these flops, so they keep
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dFourSel_r   <= `LCG_DFOUR_RST;
            gateSel_r[0] <= `LCG_GATE_RST;
            gateSel_r[1] <= `LCG_GATE_RST;
            gateSel_r[2] <= `LCG_GATE_RST;
            gateInv_r    <= `LCG_POL_RST;
        end else begin
            dFourSel_r   <= dFourSel_nxt;
            gateSel_r    <= gateSel_nxt;
            gateInv_r    <= gateInv_nxt;
        end
    end

    // read data stand only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdData_nxt = `LCG_RDATA_IDLE;
        if (busReq.rd) begin
            unique case (busReq.addr)
                `LCG_OFS_DFOUR: begin
                    rdData_nxt = {`LCG_DFOUR_PAD, dFourSel_r};
                end
                `LCG_OFS_GATE0: begin
                    rdData_nxt = gateSel_r[0];
                end
                `LCG_OFS_GATE1: begin
                    rdData_nxt = gateSel_r[1];
                end
                `LCG_OFS_GATE2: begin
                    rdData_nxt = gateSel_r[2];
                end
                `LCG_OFS_POL: begin
                    rdData_nxt = {`LCG_POL_PAD, gateInv_r};
                end
                default: begin
                end
            endcase
        end
    end

    // read data register; it falls back to idle so a stale byte never lingers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_r <= `LCG_RDATA_IDLE;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    // fourth channel source selector
    lcg_data_mux u_dfour (
        .srcSel    (dFourSel_r),
        .sourceBus (sourceBus),
        .dataLine  (lineThree)
    );

    // channels one to four map onto lines zero to three
    assign cellLines = {lineThree, cellLinesLow};

    // three gates share one implementation
    for (genvar g = 0; g < 3; g++) begin : gen_gate
        lcg_gate u_gate (
            .gateSel   (gateSel_r[g]),
            .lines     (cellLines),
            .invert    (gateInv_r[g]),
            .gateValue (gateValue[g])
        );
    end

    // outputs are registered so the mode logic sees glitch-free gates, at one cycle of latency
    always_comb begin
        gateOut_nxt = gateValue;
    end

    // gate output register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gateOut_r <= `LCG_GATEOUT_RST;
        end else begin
            gateOut_r <= gateOut_nxt;
        end
    end

    // ports come straight from the flops
    assign rdData  = rdData_r;
    assign gateOut = gateOut_r;

    // checks on the register port and the gate path
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_write(logic [2:0] a);
        busReq.wr && busReq.addr == a;
    endsequence

    sequence s_read(logic [2:0] a);
        busReq.rd && busReq.addr == a;
    endsequence

    // a write followed straight by a read of the same offset returns the written byte, masked to its stored bits
    property p_readback(logic [2:0] a, logic [7:0] m);
        s_write(a) ##1 s_read(a) |=> rdData_r == ($past(busReq.wdata, 2) & m);
    endproperty

    AST_DFOUR_FIELD: assert property (
        s_write(`LCG_OFS_DFOUR) |=> dFourSel_r == $past(busReq.wdata[5:0]))
        else $error("data four select field not stored");

    AST_DFOUR_TOP_ZERO: assert property (
        s_read(`LCG_OFS_DFOUR) |=> rdData_r[7:6] == 2'h0)
        else $error("data four select upper bits not zero");

    AST_GATE0_READBACK: assert property (p_readback(`LCG_OFS_GATE0, 8'hFF))
        else $error("gate zero enable readback wrong");

    AST_GATE1_READBACK: assert property (p_readback(`LCG_OFS_GATE1, 8'hFF))
        else $error("gate one enable readback wrong");

    AST_GATE2_READBACK: assert property (p_readback(`LCG_OFS_GATE2, 8'hFF))
        else $error("gate two enable readback wrong");

    AST_CONFIG_HOLDS: assert property (
        !busReq.wr |=> $stable(dFourSel_r) && $stable(gateSel_r[0]) && $stable(gateSel_r[1])
                       && $stable(gateSel_r[2]) && $stable(gateInv_r))
        else $error("configuration changed without a write");

    AST_EMPTY_GATE_LOW: assert property (
        gateSel_r[1] == 8'h00 && !gateInv_r[1] |=> gateOut_r[1] == 1'b0)
        else $error("gate with no enabled inputs not low");

    AST_LINE0_TRUE: assert property (
        gateSel_r[0] == 8'h02 && !gateInv_r[0] |=> gateOut_r[0] == $past(cellLinesLow[0]))
        else $error("gate zero does not follow line zero");

    AST_LINE3_INVERTED: assert property (
        gateSel_r[2] == 8'h40 && !gateInv_r[2] |=> gateOut_r[2] == !$past(sourceBus[dFourSel_r]))
        else $error("gate two does not follow inverted line three");

    AST_POL_FLIPS: assert property (
        $changed(gateInv_r[0]) && $stable(gateSel_r[0]) && $stable(cellLines)
        |=> gateOut_r[0] != $past(gateOut_r[0]))
        else $error("polarity change did not flip gate zero");

    // read data stand one cycle only; an idle bus reads zero
    AST_RDATA_IDLE: assert property (
        !busReq.rd |=> rdData_r == `LCG_RDATA_IDLE)
        else $error("read data did not return to idle");

    // back-to-back readback of the registers with unstored bits
    AST_DFOUR_READBACK: assert property (p_readback(`LCG_OFS_DFOUR, 8'h3F))
        else $error("data four select readback wrong");

    AST_POL_READBACK: assert property (p_readback(`LCG_OFS_POL, 8'h07))
        else $error("gate invert readback wrong");

    // a write to a gate offset stores the whole byte in that gate only
    property p_store(logic [2:0] a, lcg_pkg::lcg_gate_sel_t sel);
        s_write(a) |=> sel == $past(busReq.wdata);
    endproperty

    AST_GATE0_STORE: assert property (p_store(`LCG_OFS_GATE0, gateSel_r[0]))
        else $error("gate zero enable not stored");

    AST_GATE1_STORE: assert property (p_store(`LCG_OFS_GATE1, gateSel_r[1]))
        else $error("gate one enable not stored");

    AST_GATE2_STORE: assert property (p_store(`LCG_OFS_GATE2, gateSel_r[2]))
        else $error("gate two enable not stored");

    AST_POL_STORE: assert property (
        s_write(`LCG_OFS_POL) |=> gateInv_r == $past(busReq.wdata[`LCG_POL_MSB:0]))
        else $error("gate invert bits not stored");

    // writes to unmapped offsets must not leak into any register
    AST_UNMAPPED_WRITE: assert property (
        busReq.wr && busReq.addr > `LCG_OFS_POL |=> $stable(dFourSel_r) && $stable(gateSel_r[0])
            && $stable(gateSel_r[1]) && $stable(gateSel_r[2]) && $stable(gateInv_r))
        else $error("write to an unmapped offset changed a register");

    // a true and an inverted copy of one line always make the or high
    AST_GATE_BOTH_HIGH: assert property (
        gateSel_r[1] == 8'hFF && !gateInv_r[1] |=> gateOut_r[1] == 1'b1)
        else $error("gate one with every enable set not high");

    // a gate with one enable and no inversion follows that single source, one cycle late;
    // the sequence pins down the enable pattern so each bit position is checked by itself
    sequence s_sole(lcg_pkg::lcg_gate_sel_t sel, logic inv, logic [7:0] pat);
        sel == pat && !inv;
    endsequence

    property p_follows(lcg_pkg::lcg_gate_sel_t sel, logic inv, logic [7:0] pat, logic src, logic gOut);
        s_sole(sel, inv, pat) |=> gOut == $past(src);
    endproperty

    AST_G0_CH4_TRUE: assert property (
        p_follows(gateSel_r[0], gateInv_r[0], 8'h80, lineThree, gateOut_r[0]))
        else $error("gate zero does not follow channel four true");

    AST_G0_CH3_TRUE: assert property (
        p_follows(gateSel_r[0], gateInv_r[0], 8'h20, cellLinesLow[2], gateOut_r[0]))
        else $error("gate zero does not follow channel three true");

    AST_G0_CH2_INV: assert property (
        p_follows(gateSel_r[0], gateInv_r[0], 8'h04, !cellLinesLow[1], gateOut_r[0]))
        else $error("gate zero does not follow channel two inverted");

    AST_G1_CH4_INV: assert property (
        p_follows(gateSel_r[1], gateInv_r[1], 8'h40, !lineThree, gateOut_r[1]))
        else $error("gate one does not follow channel four inverted");

    AST_G1_CH3_INV: assert property (
        p_follows(gateSel_r[1], gateInv_r[1], 8'h10, !cellLinesLow[2], gateOut_r[1]))
        else $error("gate one does not follow channel three inverted");

    AST_G1_CH1_INV: assert property (
        p_follows(gateSel_r[1], gateInv_r[1], 8'h01, !cellLinesLow[0], gateOut_r[1]))
        else $error("gate one does not follow channel one inverted");

    AST_G1_CH2_TRUE: assert property (
        p_follows(gateSel_r[1], gateInv_r[1], 8'h08, cellLinesLow[1], gateOut_r[1]))
        else $error("gate one does not follow line one for channel two");

    AST_G2_CH2_TRUE: assert property (
        p_follows(gateSel_r[2], gateInv_r[2], 8'h08, cellLinesLow[1], gateOut_r[2]))
        else $error("gate two does not follow channel two true");

    AST_G2_CH4_TRUE: assert property (
        p_follows(gateSel_r[2], gateInv_r[2], 8'h80, lineThree, gateOut_r[2]))
        else $error("gate two does not follow channel four true");

endmodule : lcg_input_select

`default_nettype wire

/* rtl/lcg_cfg.svh */
// register offsets, field positions and reset values of the gate input select block
`ifndef LCG_CFG_SVH
`define LCG_CFG_SVH

`define LCG_ADDR_W        3
`define LCG_OFS_DFOUR     3'h0
`define LCG_OFS_GATE0     3'h1
`define LCG_OFS_GATE1     3'h2
`define LCG_OFS_GATE2     3'h3
`define LCG_OFS_POL       3'h4

`define LCG_DFOUR_MSB     5
`define LCG_DFOUR_LSB     0
`define LCG_DFOUR_PAD     2'h0
`define LCG_POL_MSB       2
`define LCG_POL_PAD       5'h00

`define LCG_DFOUR_RST     6'h00
`define LCG_GATE_RST      8'h00
`define LCG_POL_RST       3'h0
`define LCG_GATEOUT_RST   3'h0
`define LCG_RDATA_IDLE    8'h00

`endif

/* rtl/lcg_pkg.sv */
// types shared by the gate input select block
package lcg_pkg;

    // one register bus request, all strobes and fields together
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lcg_bus_req_t;

    // one gate enable register, bit 7 down to bit 0
    typedef struct packed {
        logic d4t;
        logic d4n;
        logic d3t;
        logic d3n;
        logic d2t;
        logic d2n;
        logic d1t;
        logic d1n;
    } lcg_gate_sel_t;

    // or of every enabled true or inverted line; nothing enabled gives zero
    function automatic logic gate_or(input lcg_gate_sel_t sel, input logic [3:0] lines);
        logic acc;
        acc = 1'b0;
        acc = acc | (sel.d1t & lines[0]) | (sel.d1n & ~lines[0]);
        acc = acc | (sel.d2t & lines[1]) | (sel.d2n & ~lines[1]);
        acc = acc | (sel.d3t & lines[2]) | (sel.d3n & ~lines[2]);
        acc = acc | (sel.d4t & lines[3]) | (sel.d4n & ~lines[3]);
        return acc;
    endfunction : gate_or

endpackage : lcg_pkg

/* rtl/lcg_data_mux.sv */
// source selector that drives the fourth data channel
`timescale 1ns/10ps
`default_nettype none

module lcg_data_mux (
    input  wire logic [5:0]  srcSel,
    input  wire logic [63:0] sourceBus,
    output logic             dataLine
);

    // every code of the 6-bit field names a source, so no code is illegal
    always_comb begin
        dataLine = sourceBus[srcSel];
    end

endmodule : lcg_data_mux

`default_nettype wire

/* rtl/lcg_gate.sv */
// one logic gate fed by its enable register, with its output polarity stage
`timescale 1ns/10ps
`default_nettype none

module lcg_gate (
    input  wire lcg_pkg::lcg_gate_sel_t gateSel,
    input  wire logic [3:0]             lines,
    input  wire logic                   invert,
    output logic                        gateValue
);

    // or of enabled lines, then the polarity bit flips the result
    always_comb begin
        gateValue = lcg_pkg::gate_or(gateSel, lines) ^ invert;
    end

endmodule : lcg_gate

`default_nettype wire

/* verif/lcg_input_select_tb.sv */
// self-checking bench for the gate input select block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic                  clk;
    logic                  resetn;
    lcg_pkg::lcg_bus_req_t busReq;
    logic [7:0]            rdData;
    logic [2:0]            cellLinesLow;
    logic [63:0]           sourceBus;
    logic [2:0]            gateOut;
    int                    err_total;
    int                    tests_run;
    int                    cycles;
    logic [3:0]            lineVec;
    logic [2:0]            gateExp;
    logic [7:0]            maskTab [8];

    lcg_input_select uut (
        .clk          (clk),
        .resetn       (resetn),
        .busReq       (busReq),
        .rdData       (rdData),
        .cellLinesLow (cellLinesLow),
        .sourceBus    (sourceBus),
        .gateOut      (gateOut)
    );

    // free running clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // one-cycle write strobe; an idle cycle follows so strobes never collide
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
    endtask : wr_reg

    // read data is only valid in the cycle after the strobe, so sample mid-cycle there
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        @(negedge clk);
        chk(rdData, exp);
        @(negedge clk);
        chk(rdData, 8'h00);
    endtask : rd_chk

    // write then read the same offset with no gap between the two strobes
    task automatic wr_rd_chk(input logic [2:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        @(negedge clk);
        chk(rdData, exp);
    endtask : wr_rd_chk

    // registered gate edge, then two spare edges for margin
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // hang guard, far above the expected thousand or so cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        resetn = 1'b0;
        busReq = '0;
        cellLinesLow = 3'h0;
        sourceBus = 64'h0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        maskTab = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00};
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        // reset values chosen as zero, unmapped places read zero
        for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
        for (int a = 0; a < 5; a++) wr_reg(3'(a), 8'hFF);
        for (int a = 5; a < 8; a++) wr_reg(3'(a), 8'hFF);
        for (int a = 0; a < 8; a++) rd_chk(3'(a), maskTab[a]);
        wr_reg(3'h0, 8'hC0);
        rd_chk(3'h0, 8'h00);
        // strobes back to back: the read right after a write sees the new byte
        for (int a = 0; a < 5; a++) wr_rd_chk(3'(a), 8'hA5, 8'hA5 & maskTab[a]);
        // reset in mid-run clears every stored field
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 5; a++) rd_chk(3'(a), 8'h00);
        // one enable bit at a time; the other channels carry the opposite level
        wr_reg(3'h0, 8'h2A);
        for (int g = 0; g < 3; g++) begin
            for (int b = 0; b < 8; b++) begin
                wr_reg(3'(g + 1), 8'(1 << b));
                for (int v = 0; v < 2; v++) begin
                    @(posedge clk);
                    lineVec = (v == 1) ? 4'h0 : 4'hF;
                    lineVec[b / 2] = v[0];
                    cellLinesLow <= lineVec[2:0];
                    sourceBus <= {64{lineVec[3]}};
                    settle();
                    gateExp = 3'h0;
                    gateExp[g] = (b % 2 == 1) ? v[0] : ~v[0];
                    chk({5'h00, gateOut}, {5'h00, gateExp});
                end
            end
            wr_reg(3'(g + 1), 8'h00);
        end
        // every enable set: a true and an inverted copy always give one
        wr_reg(3'h2, 8'hFF);
        settle();
        chk({5'h00, gateOut}, 8'h02);
        wr_reg(3'h2, 8'h00);
        // polarity bits invert each gate on its own
        wr_reg(3'h4, 8'h05);
        settle();
        chk({5'h00, gateOut}, 8'h05);
        wr_reg(3'h1, 8'hFF);
        settle();
        chk({5'h00, gateOut}, 8'h04);
        wr_reg(3'h4, 8'h00);
        // every source code of the fourth channel, seen through gate zero
        wr_reg(3'h1, 8'h80);
        for (int k = 0; k < 64; k++) begin
            wr_reg(3'h0, 8'(k));
            sourceBus <= 64'h1 << k;
            settle();
            chk({5'h00, gateOut}, 8'h01);
            @(posedge clk);
            sourceBus <= ~(64'h1 << k);
            settle();
            chk({5'h00, gateOut}, 8'h00);
            rd_chk(3'h0, 8'(k));
        end
        close_out();
    end
endmodule : testbench

`default_nettype wire
